// ===== jtag_ctrl_model.sv
module jtag_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst,
  output logic      pin0_drv,
  output logic      pin0_val,
  input  wire logic tdo,
  input  wire logic tdo_en
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst = 1'b0;
    pin0_drv = 1'b0;
    pin0_val = 1'b0;
  end

  // one 80 ns cycle with equal halves; tck rests low between frames
  task automatic step(input logic m, input logic d, output logic s, output logic e);
    tms = m;
    tdi = d;
    #20 tck = 1'b1;
    // sample well inside the high phase, the output only moves after the fall
    #20 s = tdo;
    e = tdo_en;
    #20 tck = 1'b0;
    #20;
  endtask

  task automatic route(input logic v);
    logic s, e;
    trst = 1'b0;
    pin0_drv = 1'b1;
    pin0_val = v;
    #200 trst = 1'b1;
    #200 pin0_drv = 1'b0;
    step(1'b0, 1'b1, s, e);
  endtask

  // starts and ends in run-test/idle; shifts lsb first
  task automatic shift(input logic ir, input int n, input logic [15:0] din,
                       output logic [15:0] dout, output logic oe);
    logic s, e;
    oe = 1'b1;
    dout = 16'h0000;
    step(1'b1, 1'b1, s, e);
    if (ir) step(1'b1, 1'b1, s, e);
    step(1'b0, 1'b1, s, e);
    step(1'b0, 1'b1, s, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], s, e);
      dout[i] = s;
      oe = oe & e;
    end
    step(1'b1, 1'b1, s, e);
    step(1'b0, 1'b1, s, e);
  endtask
endmodule

// ===== tap_core.sv
`include "tap_front_map.svh"
module tap_core
  import tap_front_pkg::*;
#(
  parameter int IR_W = `IR_WIDTH,
  parameter int DR_W = `DR_WIDTH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic active,
  tap_pins_if.tap   pins,
  output logic [IR_W-1:0] ir_value
);
  typedef struct packed {
    tap_state_t      st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr;
    logic            shifting;
    logic            tdo;
    logic            tdo_en;
  } core_t;
  core_t q, d;

  function automatic tap_state_t next_st(tap_state_t s, logic m);
    case (s)
      TEST_LOGIC_RESET: next_st = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE:    next_st = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR:        next_st = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR:       next_st = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         next_st = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         next_st = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         next_st = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         next_st = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        next_st = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR:        next_st = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       next_st = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         next_st = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         next_st = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         next_st = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         next_st = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        next_st = m ? SELECT_DR : RUN_TEST_IDLE;
      default:          next_st = TEST_LOGIC_RESET;
    endcase
  endfunction

  always_comb begin
    d = q;
    if (!active) begin
      // test reset low: the tap is held reset and the output floats
      d.st       = TEST_LOGIC_RESET;
      d.ir       = IR_W'(`IR_RESET);
      d.shifting = 1'b0;
      d.tdo_en   = 1'b0;
    end else begin
      if (pins.tck_rise) begin
        d.st = next_st(q.st, pins.tms);
        case (q.st)
          CAPTURE_IR: d.ir_sh = IR_W'(`IR_CAPTURE);
          SHIFT_IR:   d.ir_sh = {pins.tdi, q.ir_sh[IR_W-1:1]};
          UPDATE_IR:  d.ir = q.ir_sh;
          CAPTURE_DR: d.dr = q.dr;
          SHIFT_DR:   d.dr = {pins.tdi, q.dr[DR_W-1:1]};
          TEST_LOGIC_RESET: d.ir = IR_W'(`IR_RESET);
          default: ;
        endcase
        d.shifting = (d.st == SHIFT_IR) || (d.st == SHIFT_DR);
      end
      if (pins.tck_fall) begin
        // output moves only here, half a test clock after the shift edge
        d.tdo    = (q.st == SHIFT_IR) ? q.ir_sh[0] : q.dr[0];
        d.tdo_en = q.shifting;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: TEST_LOGIC_RESET, ir_sh: '0, ir: IR_W'(`IR_RESET), dr: '0, shifting: 1'b0, tdo: 1'b0,
             tdo_en: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign pins.tdo    = q.tdo;
  assign pins.tdo_en = q.tdo_en;
  assign ir_value    = q.ir;

  property p_tdo_on_fall;
    @(posedge clk) disable iff (rst)
      (ce && !pins.tck_fall) |=> $stable(q.tdo);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved without a falling test clock");

  property p_float_idle;
    @(posedge clk) disable iff (rst)
      (ce && pins.tck_fall && !q.shifting) |=> !q.tdo_en;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("tdo driven outside a shift");

  property p_state_on_rise;
    @(posedge clk) disable iff (rst)
      (ce && active && pins.tck_rise) |=> (q.st == next_st($past(q.st), $past(pins.tms)));
  endproperty
  a_state_on_rise: assert property (p_state_on_rise) else $error("tap state not advanced on rising test clock");
endmodule

// ===== tap_front.sv
`include "tap_front_map.svh"
// Contract
// - tms and tdi are taken into the selected tap on every rising test clock edge while test reset is high.
// - the serial test output changes only on falling test clock edges.
// - test reset high gives the scan and test system control.
// - test reset low: normal operation, test clock, tms and tdi ignored.
// - rising test reset latches emulator pin zero: 0 boundary scan, 1 emulation.
// - after test reset rises, emulator pin zero is an emulator interrupt line.
// - emulator pin one is a two-way emulator interrupt line set by emulation logic.
// - the serial test output floats except while a scan shift runs.
module tap_front
  import tap_front_pkg::*;
#(
  parameter int IR_W = `IR_WIDTH,
  parameter int DR_W = `DR_WIDTH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trst,
  output logic      tdo_o,
  output logic      tdo_oe,
  input  wire logic emulator_pin_zero_i,
  output logic      emulator_pin_zero_o,
  output logic      emulator_pin_zero_oe,
  input  wire logic emulator_pin_one_i,
  output logic      emulator_pin_one_o,
  output logic      emulator_pin_one_oe,
  input  wire logic emu_irq0_out,
  input  wire logic emu_irq0_dir,
  input  wire logic emu_irq1_out,
  input  wire logic emu_irq1_dir,
  output logic      emu_irq0_in,
  output logic      emu_irq1_in,
  output logic      test_mode,
  output logic      route_emu,
  output logic      bscan_tdo_en,
  output logic      emu_tdo_en,
  output logic [IR_W-1:0] bscan_ir,
  output logic [IR_W-1:0] emu_ir
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic       tck_prev;
    logic       trst_prev;
    logic       route;
  } front_t;
  front_t q, d;

  localparam int TCK = 0, TMS = 1, TDI = 2, TRST = 3, E0 = 4, E1 = 5;

  logic tck_s, trst_s, e0_s;
  logic rise, fall;
  logic b_act, e_act;

  // every pin input passes two flops before use
  assign tck_s  = q.s2[TCK];
  assign trst_s = q.s2[TRST];
  assign e0_s   = q.s2[E0];
  assign rise   = tck_s & ~q.tck_prev;
  assign fall   = ~tck_s & q.tck_prev;

  always_comb begin
    d           = q;
    d.s1        = {emulator_pin_one_i, emulator_pin_zero_i, trst, tdi, tms, tck};
    d.s2        = q.s1;
    d.tck_prev  = tck_s;
    d.trst_prev = trst_s;
    // strap caught on the synchronised rising test reset only
    if (trst_s && !q.trst_prev) begin
      d.route = e0_s;
    end
    // otherwise held
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{s1: '0, s2: '0, tck_prev: 1'b0, trst_prev: 1'b0, route: `ROUTE_RESET};
    end else if (ce) begin
      q <= d;
    end
  end

  // only the selected tap sees the test pins; the other stays reset
  assign test_mode = trst_s;
  assign b_act     = trst_s && (q.route == `ROUTE_BSCAN);
  assign e_act     = trst_s && (q.route == `ROUTE_EMU);
  assign route_emu = q.route;

  tap_pins_if bpins ();
  tap_pins_if epins ();
  assign bpins.tck_rise = rise & b_act;
  assign bpins.tck_fall = fall & b_act;
  assign bpins.tms      = q.s2[TMS];
  assign bpins.tdi      = q.s2[TDI];
  assign epins.tck_rise = rise & e_act;
  assign epins.tck_fall = fall & e_act;
  assign epins.tms      = q.s2[TMS];
  assign epins.tdi      = q.s2[TDI];

  tap_core #(.IR_W(IR_W), .DR_W(DR_W)) u_bscan (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .active   (b_act),
    .pins     (bpins.tap),
    .ir_value (bscan_ir)
  );

  tap_core #(.IR_W(IR_W), .DR_W(DR_W)) u_emu (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .active   (e_act),
    .pins     (epins.tap),
    .ir_value (emu_ir)
  );

  assign bscan_tdo_en = bpins.tdo_en;
  assign emu_tdo_en   = epins.tdo_en;
  assign tdo_o        = q.route ? epins.tdo : bpins.tdo;
  assign tdo_oe       = q.route ? epins.tdo_en : bpins.tdo_en;

  // pin zero becomes an interrupt line only while test reset is high
  assign emulator_pin_zero_o  = emu_irq0_out;
  assign emulator_pin_zero_oe = trst_s & emu_irq0_dir;
  assign emu_irq0_in          = trst_s & e0_s;
  assign emulator_pin_one_o   = emu_irq1_out;
  assign emulator_pin_one_oe  = emu_irq1_dir;
  assign emu_irq1_in          = q.s2[E1];

  sequence s_trst_rise;
    trst_s && !q.trst_prev;
  endsequence

  property p_latch_strap;
    @(posedge clk) disable iff (rst)
      (ce and s_trst_rise) |=> (q.route == $past(e0_s));
  endproperty
  a_latch_strap: assert property (p_latch_strap) else $error("routing not latched from pin zero");

  property p_route_hold;
    @(posedge clk) disable iff (rst)
      !(trst_s && !q.trst_prev) |=> $stable(q.route);
  endproperty
  a_route_hold: assert property (p_route_hold) else $error("routing changed without rising test reset");

  property p_ignore_low;
    @(posedge clk) disable iff (rst)
      !trst_s |-> !(bpins.tck_rise || epins.tck_rise || bpins.tck_fall || epins.tck_fall);
  endproperty
  a_ignore_low: assert property (p_ignore_low) else $error("test clock acted while test reset low");

  property p_one_tap;
    @(posedge clk) disable iff (rst)
      (b_act ^ e_act) == trst_s;
  endproperty
  a_one_tap: assert property (p_one_tap) else $error("tap selection not exclusive");

  property p_pin0_irq;
    @(posedge clk) disable iff (rst)
      emulator_pin_zero_oe |-> trst_s;
  endproperty
  a_pin0_irq: assert property (p_pin0_irq) else $error("pin zero driven while test reset low");

  property p_pin1_dir;
    @(posedge clk) disable iff (rst)
      emulator_pin_one_oe == emu_irq1_dir;
  endproperty
  a_pin1_dir: assert property (p_pin1_dir) else $error("pin one direction not from emulation logic");

  property p_tdo_float;
    @(posedge clk) disable iff (rst)
      !trst_s ##1 !trst_s |-> ##1 !tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo driven outside test mode");
endmodule

// ===== tap_front_map.svh
`ifndef TAP_FRONT_MAP_SVH
`define TAP_FRONT_MAP_SVH
`define ROUTE_BSCAN   1'b0
`define ROUTE_EMU     1'b1
`define ROUTE_RESET   1'b0
`define IR_WIDTH      4
`define DR_WIDTH      8
`define IR_RESET      4'h1
`define IR_CAPTURE    4'h1
`define SYNC_STAGES   2
`endif

// ===== tap_front_pkg.sv
package tap_front_pkg;
  typedef enum logic [15:0] {
    TEST_LOGIC_RESET = 16'h0001,
    RUN_TEST_IDLE    = 16'h0002,
    SELECT_DR        = 16'h0004,
    CAPTURE_DR       = 16'h0008,
    SHIFT_DR         = 16'h0010,
    EXIT1_DR         = 16'h0020,
    PAUSE_DR         = 16'h0040,
    EXIT2_DR         = 16'h0080,
    UPDATE_DR        = 16'h0100,
    SELECT_IR        = 16'h0200,
    CAPTURE_IR       = 16'h0400,
    SHIFT_IR         = 16'h0800,
    EXIT1_IR         = 16'h1000,
    PAUSE_IR         = 16'h2000,
    EXIT2_IR         = 16'h4000,
    UPDATE_IR        = 16'h8000
  } tap_state_t;
endpackage

// ===== tap_front_tb.sv
`include "tap_front_map.svh"
module tap_front_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk, rst, tck, tms, tdi, trst, tdo_o, tdo_oe;
  logic                 p0_drv, p0_val, p0_o, p0_oe, p1_o, p1_oe, p1_val;
  logic                 irq0_out, irq0_dir, irq1_out, irq1_dir, irq0_in, irq1_in;
  logic                 test_mode, route_emu;
  logic [`IR_WIDTH-1:0] bscan_ir, emu_ir;
  int                   n_errors, n_compared;
  // pin zero carries a pull-up, so it reads high when released; a released pin one reads p1_val
  wire logic            pin0 = p0_oe ? p0_o : (p0_drv ? p0_val : 1'b1);
  wire logic            pin1 = p1_oe ? p1_o : p1_val;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  jtag_ctrl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst(trst), .pin0_drv(p0_drv),
                       .pin0_val(p0_val), .tdo(tdo_o), .tdo_en(tdo_oe));

  tap_front uut (.clk(clk), .rst(rst), .ce(1'b1), .tck(tck), .tms(tms), .tdi(tdi), .trst(trst),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .emulator_pin_zero_i(pin0), .emulator_pin_zero_o(p0_o),
    .emulator_pin_zero_oe(p0_oe), .emulator_pin_one_i(pin1), .emulator_pin_one_o(p1_o),
    .emulator_pin_one_oe(p1_oe), .emu_irq0_out(irq0_out), .emu_irq0_dir(irq0_dir),
    .emu_irq1_out(irq1_out), .emu_irq1_dir(irq1_dir), .emu_irq0_in(irq0_in), .emu_irq1_in(irq1_in),
    .test_mode(test_mode), .route_emu(route_emu), .bscan_tdo_en(), .emu_tdo_en(),
    .bscan_ir(bscan_ir), .emu_ir(emu_ir));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic t_ignored;
    logic [15:0] d;
    logic        oe;
    cmp(route_emu, 1'b0);
    cmp(test_mode, 1'b0);
    ctl.shift(1'b1, 4, 16'h0006, d, oe);
    wait_clk(10);
    cmp(bscan_ir, 4'h1);
    cmp(oe, 1'b0);
  endtask

  task automatic t_route(input logic v);
    ctl.route(v);
    wait_clk(5);
    cmp(test_mode, 1'b1);
    cmp(route_emu, v);
    // pin zero is now released and pulled high; the choice must not follow it
    wait_clk(20);
    cmp(route_emu, v);
  endtask

  task automatic t_ir(input logic v);
    logic [15:0] d;
    logic        oe;
    ctl.shift(1'b1, 4, 16'h0006, d, oe);
    wait_clk(10);
    cmp(d[3:0], 4'h1);
    cmp(oe, 1'b1);
    cmp(tdo_oe, 1'b0);
    cmp(v ? emu_ir : bscan_ir, 4'h6);
  endtask

  task automatic t_dr;
    logic [15:0] d;
    logic        oe;
    ctl.shift(1'b0, 16, 16'h3c5a, d, oe);
    wait_clk(10);
    cmp(d[15:8], 8'h5a);
    cmp(oe, 1'b1);
    cmp(tdo_oe, 1'b0);
  endtask

  task automatic t_irq;
    irq0_dir = 1'b1;
    irq0_out = 1'b0;
    p1_val = 1'b0;
    wait_clk(4);
    cmp(p0_oe, 1'b1);
    cmp(pin0, 1'b0);
    cmp(p1_oe, 1'b0);
    cmp(irq1_in, 1'b0);
    irq0_dir = 1'b0;
    irq1_dir = 1'b1;
    p1_val = 1'b1;
    wait_clk(4);
    cmp(irq0_in, 1'b1);
    cmp(pin1, 1'b0);
    irq1_out = 1'b1;
    irq0_dir = 1'b1;
    irq0_out = 1'b1;
    p1_val = 1'b0;
    wait_clk(4);
    cmp(pin0, 1'b1);
    cmp(pin1, 1'b1);
    irq1_dir = 1'b0;
    p1_val = 1'b1;
    wait_clk(4);
    cmp(irq1_in, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    irq0_out = 1'b0;
    irq0_dir = 1'b0;
    irq1_out = 1'b0;
    irq1_dir = 1'b0;
    p1_val = 1'b1;
    n_errors = 0;
    n_compared = 0;
    wait_clk(3);
    rst = 1'b0;
    wait_clk(2);
    t_ignored;
    t_route(1'b1);
    t_ir(1'b1);
    t_route(1'b0);
    t_ir(1'b0);
    t_dr;
    t_irq;
    conclude;
  end

  initial begin
    #500us;
    n_errors++;
    conclude;
  end
endmodule

// ===== tap_pins_if.sv
interface tap_pins_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_en;
  modport ctrl (output tck_rise, output tck_fall, output tms, output tdi, input tdo, input tdo_en);
  modport tap  (input tck_rise, input tck_fall, input tms, input tdi, output tdo, output tdo_en);
endinterface
